// ==== caf_filter_chain.sv ====
`timescale 1ns/10ps
module caf_filter_chain
    import caf_pkg::*;
#(
    parameter int BLANK_CYCLES = OSC_BLANK_CYC
) (
    input  wire logic                    clk_sys_in,
    input  wire logic                    reset_n_in,
    input  wire logic                    active_mode_in,
    input  wire logic                    sleep_mode_in,
    input  wire logic                    osc_sense_in,
    input  wire logic                    osc_flag_clear_in,
    input  wire logic [6:0]              open_wire_current_control_in,
    input  wire logic [NUM_CHANNELS-1:0] modulator_bit_in,
    input  wire caf_config_t             config_in,
    input  wire logic [NUM_CELLS-1:0]    cell_enable_in,
    input  wire logic                    cell_go_in,
    input  wire logic                    cell_continuous_in,
    input  wire logic                    aux_go_in,
    input  wire logic [2:0]              aux_cell_select_in,
    input  wire logic [4:0]              aux_source_select_in,
    input  wire logic [15:0]             ref_gain_in,
    input  wire logic [15:0]             temp_coeff_in,
    input  wire logic [2:0]              read_channel_in,
    input  wire logic                    read_high_in,
    output logic                         conversion_reference_en_out,
    output logic                         protector_reference_en_out,
    output logic                         conv_ref_oscillation_flag_out,
    output logic [6:0]                   current_switch_out,
    output logic [NUM_CHANNELS-1:0]      modulator_run_out,
    output logic [2:0]                   aux_cell_mux_out,
    output logic [4:0]                   aux_source_mux_out,
    output logic                         cell_busy_out,
    output logic                         cell_ready_out,
    output logic                         aux_ready_out,
    output caf_result_t                  result_out
);
    // ---------------------------------------------------------------
    // pin synchronisers and references
    // ---------------------------------------------------------------
    logic [2:0]  osc_sync;
    logic [2:0]  next_osc_sync;
    logic [22:0] blank_cnt;
    logic [22:0] next_blank_cnt;
    logic        osc_flag;
    logic        next_osc_flag;
    logic        osc_seen;

    // third and second stages agree: first stage is not looked at
    assign osc_seen = osc_sync[1] & osc_sync[2];

    always_comb begin
        next_osc_sync = {osc_sync[1:0], osc_sense_in};
        next_blank_cnt = blank_cnt;
        if (!active_mode_in) begin
            next_blank_cnt = 23'(BLANK_CYCLES);
        end else if (blank_cnt != 23'h000000) begin
            next_blank_cnt = blank_cnt - 23'h000001;
        end
        next_osc_flag = osc_flag;
        if (osc_flag_clear_in) begin
            next_osc_flag = 1'b0;
        end
        // set wins over clear so no oscillation is lost
        if (active_mode_in && blank_cnt == 23'h000000 && osc_seen) begin
            next_osc_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            osc_sync                      <= 3'h0;
            // blank also when the device is already active at reset release
            blank_cnt                     <= 23'(BLANK_CYCLES);
            osc_flag                      <= 1'b0;
            conv_ref_oscillation_flag_out <= 1'b0;
            conversion_reference_en_out   <= 1'b0;
            protector_reference_en_out    <= 1'b0;
            current_switch_out            <= 7'h00;
            aux_cell_mux_out              <= 3'h0;
            aux_source_mux_out            <= 5'h00;
        end else begin
            osc_sync                      <= next_osc_sync;
            blank_cnt                     <= next_blank_cnt;
            osc_flag                      <= next_osc_flag;
            conv_ref_oscillation_flag_out <= next_osc_flag;
            conversion_reference_en_out   <= active_mode_in;
            protector_reference_en_out    <= active_mode_in | sleep_mode_in;
            // switches only; the host judges open wires from conversions
            current_switch_out            <= open_wire_current_control_in;
            aux_cell_mux_out              <= aux_cell_select_in;
            aux_source_mux_out            <= (aux_source_select_in > AUX_SRC_LAST) ?
                                             AUX_SRC_CELL : aux_source_select_in;
        end
    end

    // ---------------------------------------------------------------
    // conversion sequencing and decimation
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_CORRECT} caf_state_t;
    caf_state_t  state;
    caf_state_t  next_state;
    logic [8:0]  phase;
    logic [8:0]  next_phase;
    logic [1:0]  settle;
    logic [1:0]  next_settle;
    logic        aux_run;
    logic        next_aux_run;
    logic        cont;
    logic        next_cont;
    logic        cell_ready;
    logic        next_cell_ready;
    logic        aux_ready;
    logic        next_aux_ready;
    logic [1:0]  ratio_code;
    logic [8:0]  ratio_last;
    logic        dec_tick;

    logic [CIC_WIDTH-1:0] integ [NUM_CHANNELS][3];
    logic [CIC_WIDTH-1:0] comb_d [NUM_CHANNELS][3];
    logic [CIC_WIDTH-1:0] cic_out [NUM_CHANNELS];
    logic [CIC_WIDTH-1:0] cic_hold [NUM_CHANNELS];

    // aux has its own ratio; cells and die temperature share one
    assign ratio_code = aux_run ? config_in.aux_ratio : config_in.cell_ratio;
    always_comb begin
        unique case (ratio_code)
            RATIO_256: ratio_last = 9'h0FF;
            RATIO_128: ratio_last = 9'h07F;
            RATIO_64:  ratio_last = 9'h03F;
            RATIO_32:  ratio_last = 9'h01F;
        endcase
    end
    assign dec_tick = (state == ST_RUN) && (phase == ratio_last);

    always_comb begin
        next_state      = state;
        next_phase      = phase;
        next_settle     = settle;
        next_aux_run    = aux_run;
        next_cont       = cont;
        next_cell_ready = cell_ready;
        next_aux_ready  = aux_ready;
        if (cell_go_in || aux_go_in) begin
            // a new start aborts any running conversion
            next_state   = ST_RUN;
            next_phase   = 9'h000;
            next_settle  = 2'h0;
            next_aux_run = aux_go_in & ~cell_go_in;
            next_cont    = cell_go_in & (cell_continuous_in | config_in.lowpass_enable);
            if (cell_go_in) next_cell_ready = 1'b0;
            if (aux_go_in)  next_aux_ready  = 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: ;
                ST_RUN: begin
                    next_phase = dec_tick ? 9'h000 : phase + 9'h001;
                    // comb pipeline needs three output ticks to fill
                    if (dec_tick) begin
                        if (settle == 2'h3) next_state = ST_CORRECT;
                        else next_settle = settle + 2'h1;
                    end
                end
                ST_CORRECT: begin
                    if (aux_run) next_aux_ready = 1'b1;
                    else next_cell_ready = 1'b1;
                    next_state = cont ? ST_RUN : ST_IDLE;
                    next_phase = 9'h000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state          <= ST_IDLE;
            phase          <= 9'h000;
            settle         <= 2'h0;
            aux_run        <= 1'b0;
            cont           <= 1'b0;
            cell_ready     <= 1'b0;
            aux_ready      <= 1'b0;
            cell_ready_out <= 1'b0;
            aux_ready_out  <= 1'b0;
            cell_busy_out  <= 1'b0;
        end else begin
            state          <= next_state;
            phase          <= next_phase;
            settle         <= next_settle;
            aux_run        <= next_aux_run;
            cont           <= next_cont;
            cell_ready     <= next_cell_ready;
            aux_ready      <= next_aux_ready;
            cell_ready_out <= next_cell_ready;
            aux_ready_out  <= next_aux_ready;
            cell_busy_out  <= (next_state != ST_IDLE) && !next_aux_run;
        end
    end

    // integrators at modulator rate, combs at decimated rate; widths
    // of 1 + 3*8 bits make wrap-around exact for every ratio
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_cic
        logic             run_ch;
        logic [CIC_WIDTH-1:0] c1;
        logic [CIC_WIDTH-1:0] c2;
        assign run_ch = (ch < NUM_CELLS) ? (cell_enable_in[ch] && !aux_run) :
                        (ch == CH_AUX) ? aux_run : !aux_run;
        assign c1 = integ[ch][2] - comb_d[ch][0];
        assign c2 = c1 - comb_d[ch][1];
        assign cic_out[ch] = c2 - comb_d[ch][2];
        always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                integ[ch]    <= '{default: '0};
                comb_d[ch]   <= '{default: '0};
                cic_hold[ch] <= '0;
            end else if (cell_go_in || aux_go_in) begin
                integ[ch]  <= '{default: '0};
                comb_d[ch] <= '{default: '0};
            end else if (state == ST_RUN && run_ch) begin
                // one-bit stream taken as +1/-1 around midscale
                integ[ch][0] <= integ[ch][0] + (modulator_bit_in[ch] ?
                                CIC_WIDTH'(1) : {CIC_WIDTH{1'b1}});
                integ[ch][1] <= integ[ch][1] + integ[ch][0];
                integ[ch][2] <= integ[ch][2] + integ[ch][1];
                if (dec_tick) begin
                    comb_d[ch][0] <= integ[ch][2];
                    comb_d[ch][1] <= c1;
                    comb_d[ch][2] <= c2;
                    // held here: the integrators step once more before correction
                    cic_hold[ch]  <= cic_out[ch];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // correction, lowpass and held results
    // ---------------------------------------------------------------
    logic [RAW_WIDTH-1:0]  raw [NUM_CHANNELS];
    logic [CORR_WIDTH-1:0] corr [NUM_CHANNELS];
    logic [RAW_WIDTH-1:0]  lp [NUM_CELLS];
    logic [RAW_WIDTH-1:0]  raw_fix [NUM_CHANNELS];
    logic [4:0]            norm;
    logic [39:0]           temp_term;
    logic [RAW_WIDTH-1:0]  raw_new [NUM_CHANNELS];
    logic [RAW_WIDTH-1:0]  temp_now;

    // align to 24 bits so every ratio lands at full scale
    always_comb begin
        unique case (ratio_code)
            RATIO_256: norm = 5'h00;
            RATIO_128: norm = 5'h03;
            RATIO_64:  norm = 5'h06;
            RATIO_32:  norm = 5'h09;
        endcase
    end
    // cells use this run's die temperature; aux falls back on the last cell run
    assign temp_now  = RAW_WIDTH'(cic_hold[CH_TEMP] << norm);
    assign temp_term = 40'($signed(temp_coeff_in) *
                           $signed(aux_run ? raw[CH_TEMP][23:8] : temp_now[23:8]));

    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_res
        logic [RAW_WIDTH-1:0] aligned;
        logic [39:0]          prod;
        logic                 take;
        assign aligned = RAW_WIDTH'(cic_hold[ch] << norm);
        assign raw_new[ch] = aligned;
        assign prod = 40'($signed(aligned) * $signed({1'b0, ref_gain_in}));
        // gain and die-temperature offset; cost is the extra cycle
        assign raw_fix[ch] = prod[38:15] + temp_term[39:16];
        assign take = (state == ST_CORRECT) && ((ch == CH_AUX) == aux_run) &&
                      (ch >= NUM_CELLS || cell_enable_in[ch]);
        always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                raw[ch]  <= RAW_PRESET;
                corr[ch] <= CORR_PRESET;
            end else if ((cell_go_in && ch != CH_AUX) || (aux_go_in && ch == CH_AUX)) begin
                raw[ch]  <= RAW_PRESET;
                corr[ch] <= CORR_PRESET;
            end else if (take) begin
                raw[ch]  <= aligned;
                corr[ch] <= raw_fix[ch][23:8];
            end
        end
    end

    // y += (x - y) >>> shift: shift-only first-order recursion
    for (genvar ch = 0; ch < NUM_CELLS; ch++) begin : g_lp
        logic [RAW_WIDTH-1:0] src;
        logic [RAW_WIDTH-1:0] diff;
        assign src = (config_in.filter_source_select && config_in.uncorrected_filter_select) ?
                     raw_new[ch] : {raw_fix[ch][23:8], 8'h00};
        // fed from the result being stored, not the registers still holding the preset or the previous result
        // shift+1 gives the halving corner per code
        assign diff = RAW_WIDTH'($signed(src - lp[ch]) >>>
                      (5'(config_in.lowpass_shift_select) + 5'h01));
        always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                lp[ch] <= RAW_PRESET;
            end else if (state == ST_CORRECT && !aux_run && cell_enable_in[ch]) begin
                lp[ch] <= lp[ch] + diff;
            end
        end
    end

    // high byte read snapshots all bytes of one conversion
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            result_out        <= '{RAW_PRESET, CORR_PRESET, CORR_PRESET};
            modulator_run_out <= '0;
        end else begin
            modulator_run_out <= (state == ST_RUN) ?
                {~aux_run, aux_run, cell_enable_in & {NUM_CELLS{~aux_run}}} : '0;
            if (read_high_in) begin
                result_out.raw  <= raw[read_channel_in];
                result_out.corr <= corr[read_channel_in];
                result_out.filt <= (read_channel_in < 3'(NUM_CELLS)) ?
                    lp[read_channel_in][23:8] : corr[read_channel_in];
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_blank;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (blank_cnt != 23'h000000 && !osc_flag) |=> !osc_flag;
    endproperty
    a_blank: assert property (p_blank) else $error("flag set during blanking");
    property p_ref;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        conversion_reference_en_out |-> protector_reference_en_out;
    endproperty
    a_ref: assert property (p_ref) else $error("reference enables inconsistent");
    property p_preset;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        cell_go_in |=> corr[0] == CORR_PRESET && raw[0] == RAW_PRESET;
    endproperty
    a_preset: assert property (p_preset) else $error("start did not preset");
    property p_freeze;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        !read_high_in |=> $stable(result_out);
    endproperty
    a_freeze: assert property (p_freeze) else $error("result changed without high read");
    property p_ready;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (state == ST_CORRECT && !aux_run && !cell_go_in && !aux_go_in) |=> cell_ready_out;
    endproperty
    a_ready: assert property (p_ready) else $error("ready missed");
    property p_cont;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (cell_go_in && config_in.lowpass_enable) |=> cont;
    endproperty
    a_cont: assert property (p_cont) else $error("lowpass not continuous");
    property p_sw;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        1'b1 |=> current_switch_out == $past(open_wire_current_control_in);
    endproperty
    a_sw: assert property (p_sw) else $error("current switch mismatch");
    property p_dec;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (state == ST_RUN && phase == 9'h000 && !config_in.cell_ratio[1] && !aux_run
         && config_in.cell_ratio[0]) |-> ##[1:140] (phase == 9'h000 || state != ST_RUN);
    endproperty
    a_dec: assert property (p_dec) else $error("decimation period wrong");
endmodule

// ==== caf_pkg.sv ====
package caf_pkg;
    // ---------------------------------------------------------------
    // sizes and codes
    // ---------------------------------------------------------------
    localparam int          NUM_CELLS     = 6;
    localparam int          NUM_CHANNELS  = 8;
    localparam int          CH_AUX        = 6;
    localparam int          CH_TEMP       = 7;
    localparam int          CIC_WIDTH     = 25;
    localparam int          CORR_WIDTH    = 16;
    localparam int          RAW_WIDTH     = 24;
    localparam logic [15:0] CORR_PRESET   = 16'h8000;
    localparam logic [23:0] RAW_PRESET    = 24'h800000;
    localparam logic [1:0]  RATIO_256     = 2'h0;
    localparam logic [1:0]  RATIO_128     = 2'h1;
    localparam logic [1:0]  RATIO_64      = 2'h2;
    localparam logic [1:0]  RATIO_32      = 2'h3;
    localparam logic [4:0]  AUX_SRC_CELL  = 5'h00;
    localparam logic [4:0]  AUX_SRC_LAST  = 5'h14;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          OSC_BLANK_MS  = 10;
    localparam int          OSC_BLANK_CYC = CLK_HZ / 1000 * OSC_BLANK_MS;

    // result group read by the host
    typedef struct packed {
        logic [23:0] raw;
        logic [15:0] corr;
        logic [15:0] filt;
    } caf_result_t;

    // configuration steering the chain
    typedef struct packed {
        logic [1:0] cell_ratio;
        logic [1:0] aux_ratio;
        logic [2:0] lowpass_shift_select;
        logic       lowpass_enable;
        logic       filter_source_select;
        logic       uncorrected_filter_select;
    } caf_config_t;
endpackage

// ==== caf_modulator_model.sv ====
`timescale 1ns/10ps
// -----------------------------------------------------------
// first-order pulse-density stand-in for the analog modulators
// -----------------------------------------------------------
// behavioural only: the carry of an accumulator gives a density of level/256,
// good enough to exercise the decimator without modelling noise shaping
module caf_modulator_model
    import caf_pkg::*;
(
    input  wire logic                    clk_sys_in,
    input  wire logic                    reset_n_in,
    input  wire logic [7:0]              level_in,
    output logic      [NUM_CHANNELS-1:0] bit_out
);
    logic [8:0] acc;

    // one accumulator feeds every channel so all streams share a density
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            acc <= 9'h000;
        end else begin
            acc <= {1'b0, acc[7:0]} + {1'b0, level_in};
        end
    end
    assign bit_out = {NUM_CHANNELS{acc[8]}};
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
    import caf_pkg::*;
    localparam int BLANK = 20;
    // density 3/8 gives -1/4 of full scale at every ratio, unity gain
    localparam logic [23:0] RAW_EXP = 24'hC00000;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic act = 1'b0, slp = 1'b0, osc = 1'b0, oclr = 1'b0, cgo = 1'b0, cont = 1'b0;
    logic ago = 1'b0, rdh = 1'b0;
    logic [6:0] owc = 7'h00;
    logic [7:0] lvl = 8'h60;
    logic [5:0] cen = 6'h3F;
    logic [NUM_CHANNELS-1:0] mbit, mrun;
    caf_config_t cfg = '0;
    logic [2:0] rch = 3'h0, acel = 3'h0, acm;
    logic [4:0] asrc = 5'h00, asm;
    logic cre, pre, oflag, busy, crdy, ardy;
    logic [6:0] csw;
    caf_result_t res;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    caf_modulator_model caf_modulator_model_inst (.clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in), .level_in(lvl), .bit_out(mbit));
    caf_filter_chain #(.BLANK_CYCLES(BLANK)) caf_filter_chain_inst (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .active_mode_in(act),
        .sleep_mode_in(slp), .osc_sense_in(osc), .osc_flag_clear_in(oclr),
        .open_wire_current_control_in(owc), .modulator_bit_in(mbit), .config_in(cfg),
        .cell_enable_in(cen), .cell_go_in(cgo), .cell_continuous_in(cont),
        .aux_go_in(ago), .aux_cell_select_in(acel), .aux_source_select_in(asrc),
        .ref_gain_in(16'h8000), .temp_coeff_in(16'h0000), .read_channel_in(rch),
        .read_high_in(rdh), .conversion_reference_en_out(cre),
        .protector_reference_en_out(pre), .conv_ref_oscillation_flag_out(oflag),
        .current_switch_out(csw), .modulator_run_out(mrun), .aux_cell_mux_out(acm),
        .aux_source_mux_out(asm), .cell_busy_out(busy), .cell_ready_out(crdy),
        .aux_ready_out(ardy), .result_out(res));
    // -----------------------------------------------------------
    // helpers
    // -----------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    // a read pulse is taken at one edge; result settles one cycle later
    task automatic read_ch(input logic [2:0] ch);
        @(posedge clk_sys_in);
        rch <= ch;
        rdh <= 1'b1;
        @(posedge clk_sys_in);
        rdh <= 1'b0;
        tick(1);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // cycle ceiling covers four conversions at ratio 256 with margin
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc > 20000) begin
            err_count++;
            give_verdict();
        end
    end
    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic t_refs_wire;
        @(posedge clk_sys_in);
        slp <= 1'b1;
        owc <= 7'h41;
        asrc <= 5'h15;
        acel <= 3'h5;
        tick(4);
        chk("conv_ref_sleep", 24'h0, cre);
        chk("prot_ref_sleep", 24'h1, pre);
        chk("switches", 24'h41, csw);
        chk("aux_src_bad", 24'h0, asm);
        chk("aux_cell", 24'h5, acm);
        @(posedge clk_sys_in);
        slp <= 1'b0;
        act <= 1'b1;
        osc <= 1'b1;
        asrc <= AUX_SRC_LAST;
        tick(4);
        chk("conv_ref_act", 24'h1, cre);
        chk("prot_ref_act", 24'h1, pre);
        chk("aux_src_last", AUX_SRC_LAST, asm);
        tick(BLANK - 8);
        chk("osc_blanked", 24'h0, oflag);
        tick(20);
        chk("osc_set", 24'h1, oflag);
        @(posedge clk_sys_in);
        osc <= 1'b0;
        tick(6);
        chk("osc_sticky", 24'h1, oflag);
        @(posedge clk_sys_in);
        oclr <= 1'b1;
        @(posedge clk_sys_in);
        oclr <= 1'b0;
        tick(2);
        chk("osc_cleared", 24'h0, oflag);
        $display("test refs_wire done");
    endtask
    // each ratio: preset on start, ready near ratio*4 cycles, fresh snapshot
    // shift code 0 halves the lowpass gap to the result at each conversion
    task automatic t_cell(input logic [1:0] code, input int ratio, input logic [15:0] filt_exp);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        cfg.cell_ratio <= code;
        cgo <= 1'b1;
        @(posedge clk_sys_in);
        cgo <= 1'b0;
        #1;
        chk("busy", 24'h1, busy);
        chk("ready_low", 24'h0, crdy);
        read_ch(3'h2);
        chk("raw_preset", RAW_PRESET, res.raw);
        chk("corr_preset", CORR_PRESET, res.corr);
        n = 2;
        while (crdy !== 1'b1 && n < ratio * 4 + 20) begin
            tick(1);
            n++;
        end
        chk("ready_late", 24'h0, n > ratio * 4 + 8);
        chk("ready_early", 24'h0, n < ratio * 4);
        read_ch(3'h2);
        chk("raw_fresh", RAW_EXP, res.raw);
        chk("corr_fresh", 24'(RAW_EXP[23:8]), res.corr);
        chk("filt_step", 24'(filt_exp), res.filt);
        read_ch(3'(CH_TEMP));
        chk("temp_fresh", RAW_EXP, res.raw);
        $display("test cell ratio %0d done", ratio);
    endtask
    task automatic t_abort_aux;
        @(posedge clk_sys_in);
        cfg.cell_ratio <= RATIO_32;
        cfg.aux_ratio <= RATIO_32;
        cgo <= 1'b1;
        @(posedge clk_sys_in);
        cgo <= 1'b0;
        tick(60);
        @(posedge clk_sys_in);
        cgo <= 1'b1;
        @(posedge clk_sys_in);
        cgo <= 1'b0;
        tick(100);
        chk("restart_ready", 24'h0, crdy);
        @(posedge clk_sys_in);
        ago <= 1'b1;
        @(posedge clk_sys_in);
        ago <= 1'b0;
        tick(160);
        chk("aux_ready", 24'h1, ardy);
        read_ch(3'(CH_AUX));
        chk("aux_fresh", RAW_EXP, res.raw);
        $display("test abort_aux done");
    endtask
    // lowpass forces continuous runs; a disabled cell keeps its preset
    task automatic t_cont;
        @(posedge clk_sys_in);
        cfg.cell_ratio <= RATIO_32;
        cfg.lowpass_enable <= 1'b1;
        cen <= 6'h3E;
        cgo <= 1'b1;
        @(posedge clk_sys_in);
        cgo <= 1'b0;
        tick(2);
        chk("mod_run", 24'hBE, mrun);
        tick(4 * 32);
        chk("cont_busy", 24'h1, busy);
        chk("cont_ready", 24'h1, crdy);
        read_ch(3'h1);
        chk("cont_raw", RAW_EXP, res.raw);
        chk("cont_filt", 24'hBE00, res.filt);
        read_ch(3'h0);
        chk("cell0_skip", RAW_PRESET, res.raw);
        @(posedge clk_sys_in);
        cfg.lowpass_enable <= 1'b0;
        cgo <= 1'b1;
        @(posedge clk_sys_in);
        cgo <= 1'b0;
        tick(4 * 32 + 10);
        chk("cont_stop", 24'h0, busy);
        $display("test cont done");
    endtask
    initial begin
        // reset starts low with no edge, so it only acts at the first clock
        @(posedge clk_sys_in);
        #1;
        chk("reset_raw", RAW_PRESET, res.raw);
        chk("reset_ready", 24'h0, crdy);
        repeat (7) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        t_refs_wire();
        t_cell(RATIO_32, 32, 16'hA000);
        t_cell(RATIO_64, 64, 16'hB000);
        t_cell(RATIO_128, 128, 16'hB800);
        t_cell(RATIO_256, 256, 16'hBC00);
        t_abort_aux();
        t_cont();
        give_verdict();
    end
endmodule
